// File: logic/dsrcr_pkg.sv
package dsrcr_pkg;

    localparam logic [7:0] DSRCR_OFS_ADDR = 8'h00;
    localparam logic [7:0] DSRCR_OFS_RST = 8'h01;
    localparam logic [7:0] DSRCR_OFS_GCFG0 = 8'h02;

    localparam logic [7:0] DSRCR_RST_ADDR = 8'hC0;
    localparam logic [7:0] DSRCR_RST_RST = 8'h04;
    localparam logic [7:0] DSRCR_RST_GCFG0 = 8'h00;

    localparam int DSRCR_BIT_SRC_SEL = 0;
    localparam int DSRCR_BIT_APWDN = 5;
    localparam int DSRCR_BIT_DRST1 = 1;
    localparam int DSRCR_BIT_DRST0 = 0;
    localparam int DSRCR_BIT_AUTOCLK = 5;

    localparam logic [7:0] DSRCR_RSVD_RST_MASK = 8'hDC;
    localparam logic [7:0] DSRCR_RSVD_GCFG0_MASK = 8'hDF;
    localparam logic [7:0] DSRCR_UNMAPPED_READ = 8'h00;

    // Cycles a logic reset pulse is held
    localparam logic [3:0] DSRCR_RESET_PULSE_CYCLES = 4'h4;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } dsrcr_req_t;

    typedef enum logic [1:0] {
        DSRCR_CLK_OFF,
        DSRCR_CLK_RECOVERED,
        DSRCR_CLK_OSC
    } dsrcr_clk_sel_t;

endpackage : dsrcr_pkg

// File: logic/dsrcr_pulse.sv
`timescale 1ns/100ps
module dsrcr_pulse
    import dsrcr_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic trigger,
    output logic pulse
);

    logic [3:0] count;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            count <= 4'h0;
        end else if (trigger) begin
            count <= DSRCR_RESET_PULSE_CYCLES;
        end else if (count != 4'h0) begin
            count <= count - 4'h1;
        end
    end

    assign pulse = (count != 4'h0);

endmodule : dsrcr_pulse

// File: logic/dsrcr_regs.sv
`timescale 1ns/100ps
module dsrcr_regs
    import dsrcr_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire dsrcr_req_t local_req,
    output logic [7:0] local_rdata,
    input wire dsrcr_req_t remote_req,
    output logic [7:0] remote_rdata,
    input wire logic [6:0] address_strap_input,
    input wire logic link_a,
    output logic [6:0] own_bus_target_address,
    output logic analog_power_down,
    output logic logic_reset_pulse,
    output logic full_reset_pulse,
    output dsrcr_clk_sel_t clk_sel
);

    ////////////////////////////////////////////////////////////////////////////////
    // Register state

    logic [7:0] addr_reg;
    logic [7:0] rst_reg;
    logic [7:0] gcfg0_reg;
    logic [7:0] local_rd_q;
    logic [7:0] remote_rd_q;
    logic soft_full_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Request fields

    wire local_wr = local_req.wr;
    wire local_rd = local_req.rd;
    wire remote_rd = remote_req.rd;

    // Local write wins on collision
    wire remote_wr = remote_req.wr && !local_req.wr;
    wire any_wr = local_wr || remote_wr;

    ////////////////////////////////////////////////////////////////////////////////
    // Write decode

    wire [7:0] wr_addr = local_wr ? local_req.addr : remote_req.addr;
    wire [7:0] wr_data = local_wr ? local_req.wdata : remote_req.wdata;
    // Writes that reach one of the three registers
    wire wr_addr_sel = any_wr && (wr_addr == DSRCR_OFS_ADDR);
    wire wr_rst_sel = any_wr && (wr_addr == DSRCR_OFS_RST);
    wire wr_gcfg0_sel = any_wr && (wr_addr == DSRCR_OFS_GCFG0);

    // Reset requests taken from the write data
    wire start_logic_reset = wr_rst_sel && wr_data[DSRCR_BIT_DRST1];
    wire start_full_reset = wr_rst_sel && wr_data[DSRCR_BIT_DRST0];
    wire reg_rstn = rstn && !soft_full_q;

    // Remote writes keep the power-down bit
    wire next_apwdn = local_wr ? wr_data[DSRCR_BIT_APWDN] : rst_reg[DSRCR_BIT_APWDN];

    ////////////////////////////////////////////////////////////////////////////////
    // Read decode, local port

    wire local_rd_addr_hit = (local_req.addr == DSRCR_OFS_ADDR);
    wire local_rd_rst_hit = (local_req.addr == DSRCR_OFS_RST);
    wire local_rd_gcfg0_hit = (local_req.addr == DSRCR_OFS_GCFG0);

    wire [7:0] local_rd_val = local_rd_addr_hit ? addr_reg :
                              local_rd_rst_hit ? rst_reg :
                              local_rd_gcfg0_hit ? gcfg0_reg :
                              DSRCR_UNMAPPED_READ;

    ////////////////////////////////////////////////////////////////////////////////
    // Read decode, remote port
    // Remote reads see the power-down bit too

    wire remote_rd_addr_hit = (remote_req.addr == DSRCR_OFS_ADDR);
    wire remote_rd_rst_hit = (remote_req.addr == DSRCR_OFS_RST);
    wire remote_rd_gcfg0_hit = (remote_req.addr == DSRCR_OFS_GCFG0);

    wire [7:0] remote_rd_val = remote_rd_addr_hit ? addr_reg :
                               remote_rd_rst_hit ? rst_reg :
                               remote_rd_gcfg0_hit ? gcfg0_reg :
                               DSRCR_UNMAPPED_READ;

    ////////////////////////////////////////////////////////////////////////////////
    // Next register values

    wire [7:0] next_addr_reg = wr_data;
    wire [7:0] rst_keep = DSRCR_RST_RST & DSRCR_RSVD_RST_MASK;
    wire [7:0] rst_live = {2'h0, next_apwdn, 5'h00};
    wire [7:0] next_rst_reg = rst_keep | rst_live;
    wire [7:0] gcfg0_keep = DSRCR_RST_GCFG0 & DSRCR_RSVD_GCFG0_MASK;
    wire [7:0] next_gcfg0_reg = gcfg0_keep | (wr_data & ~DSRCR_RSVD_GCFG0_MASK);
    // Read capture
    wire [7:0] next_local_rd = local_rd ? local_rd_val : local_rd_q;
    wire [7:0] next_remote_rd = remote_rd ? remote_rd_val : remote_rd_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Register writes

    // Own bus address and its source bit
    always_ff @(posedge clk) begin
        if (!reg_rstn) begin
            addr_reg <= DSRCR_RST_ADDR;
        end else if (wr_addr_sel) begin
            addr_reg <= next_addr_reg;
        end
    end

    // Self-clearing bits never store
    always_ff @(posedge clk) begin
        if (!reg_rstn) begin
            rst_reg <= DSRCR_RST_RST;
        end else if (wr_rst_sel) begin
            rst_reg <= next_rst_reg;
        end
    end

    // Reserved bits keep their default
    always_ff @(posedge clk) begin
        if (!reg_rstn) begin
            gcfg0_reg <= DSRCR_RST_GCFG0;
        end else if (wr_gcfg0_sel) begin
            gcfg0_reg <= next_gcfg0_reg;
        end
    end

    // Full reset clears the registers one cycle after the write
    always_ff @(posedge clk) begin
        if (!rstn) begin
            soft_full_q <= 1'b0;
        end else begin
            soft_full_q <= start_full_reset;
        end
    end

    // Read data holds until the next read on its port or a full reset
    always_ff @(posedge clk) begin
        if (!reg_rstn) begin
            local_rd_q <= 8'h00;
        end else begin
            local_rd_q <= next_local_rd;
        end
    end

    always_ff @(posedge clk) begin
        if (!reg_rstn) begin
            remote_rd_q <= 8'h00;
        end else begin
            remote_rd_q <= next_remote_rd;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Reset pulses

    // Logic reset keeps registers
    dsrcr_pulse u_logic_pulse (
        .clk(clk),
        .rstn(reg_rstn),
        .trigger(start_logic_reset),
        .pulse(logic_reset_pulse)
    );

    // Full reset pulse survives its own register reset
    dsrcr_pulse u_full_pulse (
        .clk(clk),
        .rstn(rstn),
        .trigger(start_full_reset),
        .pulse(full_reset_pulse)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Field views

    wire addr_override = addr_reg[DSRCR_BIT_SRC_SEL];
    wire [6:0] addr_field = addr_reg[7:1];
    wire auto_clock = gcfg0_reg[DSRCR_BIT_AUTOCLK];
    wire [1:0] clk_mode = {link_a, auto_clock};

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign local_rdata = local_rd_q;
    assign remote_rdata = remote_rd_q;
    // Strap address unless the register overrides it
    assign own_bus_target_address = addr_override ? addr_field : address_strap_input;
    assign analog_power_down = rst_reg[DSRCR_BIT_APWDN];

    // Link_a link always gets the recovered clock
    always_comb begin
        case (clk_mode)
            2'h0: begin
                clk_sel = DSRCR_CLK_OFF;
            end
            2'h1: begin
                clk_sel = DSRCR_CLK_OSC;
            end
            2'h2: begin
                clk_sel = DSRCR_CLK_RECOVERED;
            end
            2'h3: begin
                clk_sel = DSRCR_CLK_RECOVERED;
            end
            default: begin
                clk_sel = DSRCR_CLK_OFF;
            end
        endcase
    end

endmodule : dsrcr_regs

// File: tb/deserializer_control_registers_bench.sv
`timescale 1ns/100ps
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin errors++; $display("[ERR] %s exp %h got %h", n, e, s); end end
module deserializer_control_registers_bench
    import dsrcr_pkg::*;
;
    logic clk = 0;
    logic rstn = 0;
    logic [6:0] strap = 7'h2B;
    logic link_a = 0;
    dsrcr_req_t lreq, rreq;
    logic [7:0] lrd, rrd, d, e;
    logic [6:0] own;
    logic apd, lrp, frp;
    dsrcr_clk_sel_t csel;
    int errors = 0;
    int checks_done = 0;
    // Rows: address, write data, read back
    logic [23:0] rows [7] = '{24'h00A5A5, 24'h003C3C, 24'h012424, 24'h012624, 24'h022020, 24'h020000, 24'h05FF00};
    always #5 clk = ~clk;
    dsrcr_regs dut (.clk(clk), .rstn(rstn), .local_req(lreq), .local_rdata(lrd), .remote_req(rreq),
        .remote_rdata(rrd), .address_strap_input(strap), .link_a(link_a), .own_bus_target_address(own),
        .analog_power_down(apd), .logic_reset_pulse(lrp), .full_reset_pulse(frp), .clk_sel(csel));
    dsrcr_host hl (.clk(clk), .rdata(lrd), .req(lreq));
    dsrcr_host hr (.clk(clk), .rdata(rrd), .req(rreq));
    task automatic complete_run;
        $display("errors %0d checks %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : complete_run
    initial begin
        #200000;
        errors++;
        complete_run;
    end
    initial begin
        repeat (4) @(posedge clk);
        #1 rstn = 1;
        hl.xfer(0, DSRCR_OFS_ADDR, 8'h00, d); `CHK("addr", DSRCR_RST_ADDR, d)
        hl.xfer(0, DSRCR_OFS_RST, 8'h00, d); `CHK("rst", DSRCR_RST_RST, d)
        hl.xfer(0, DSRCR_OFS_GCFG0, 8'h00, d); `CHK("gcfg0", DSRCR_RST_GCFG0, d)
        foreach (rows[i]) begin
            hl.xfer(1, rows[i][23:16], rows[i][15:8], d);
            hl.xfer(0, rows[i][23:16], 8'h00, d);
            `CHK("row", rows[i][7:0], d)
        end
        `CHK("strap", strap, own)
        hl.xfer(1, DSRCR_OFS_ADDR, 8'hA5, d);
        `CHK("own", 7'h52, own)
        hr.xfer(1, DSRCR_OFS_RST, 8'h04, d);
        `CHK("apd", 1'b1, apd)
        hr.xfer(0, DSRCR_OFS_RST, 8'h00, d);
        `CHK("rrd", 8'h24, d)
        hl.xfer(1, DSRCR_OFS_GCFG0, 8'h20, d);
        `CHK("osc", DSRCR_CLK_OSC, csel)
        link_a = 1;
        @(posedge clk);
        #1 `CHK("rec", DSRCR_CLK_RECOVERED, csel)
        fork
            hl.xfer(1, DSRCR_OFS_GCFG0, 8'h00, d);
            hr.xfer(1, DSRCR_OFS_GCFG0, 8'h20, e);
        join
        link_a = 0;
        @(posedge clk);
        #1 `CHK("off", DSRCR_CLK_OFF, csel)
        hl.xfer(1, DSRCR_OFS_RST, 8'h25, d);
        `CHK("frp", 1'b1, frp)
        `CHK("apd0", 1'b0, apd)
        hl.xfer(0, DSRCR_OFS_ADDR, 8'h00, d); `CHK("faddr", DSRCR_RST_ADDR, d)
        hl.xfer(0, DSRCR_OFS_RST, 8'h00, d); `CHK("frst", DSRCR_RST_RST, d)
        hl.xfer(1, DSRCR_OFS_RST, 8'h26, d);
        `CHK("lrp", 1'b1, lrp)
        `CHK("apdk", 1'b1, apd)
        hl.xfer(1, DSRCR_OFS_ADDR, 8'hA5, d);
        `CHK("own2", 7'h52, own)
        rstn = 0;
        @(posedge clk);
        #1 rstn = 1;
        hl.xfer(0, DSRCR_OFS_ADDR, 8'h00, d); `CHK("raddr", DSRCR_RST_ADDR, d)
        `CHK("rown", strap, own)
        `CHK("rapd", 1'b0, apd)
        complete_run;
    end
endmodule : deserializer_control_registers_bench

// File: tb/dsrcr_host.sv
`timescale 1ns/100ps
module dsrcr_host
    import dsrcr_pkg::*;
(
    input wire logic clk,
    input wire logic [7:0] rdata,
    output dsrcr_req_t req
);
    initial req = '0;
    // One request cycle, read data taken after the second edge
    task automatic xfer(input logic wr, input logic [7:0] addr, input logic [7:0] wdata, output logic [7:0] rd);
        req = '{wr, !wr, addr, wdata};
        @(posedge clk);
        #1 req = '0;
        @(posedge clk);
        #1 rd = rdata;
    endtask : xfer
endmodule : dsrcr_host

// File: tb/dsrcr_regs_asserts.sv
`timescale 1ns/100ps
module dsrcr_regs_asserts
    import dsrcr_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire dsrcr_req_t local_req,
    input wire dsrcr_req_t remote_req,
    input wire logic [6:0] address_strap_input,
    input wire logic link_a,
    input wire logic [6:0] own_bus_target_address,
    input wire logic analog_power_down,
    input wire logic logic_reset_pulse,
    input wire logic full_reset_pulse,
    input wire dsrcr_clk_sel_t clk_sel
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    wire lw0 = local_req.wr && local_req.addr == DSRCR_OFS_ADDR;
    wire lw1 = local_req.wr && local_req.addr == DSRCR_OFS_RST;
    wire lw2 = local_req.wr && local_req.addr == DSRCR_OFS_GCFG0;
    wire rw1 = remote_req.wr && remote_req.addr == DSRCR_OFS_RST && !local_req.wr;
    a_strap_source: assert property (lw0 && !local_req.wdata[0] |=> own_bus_target_address == address_strap_input)
        else $error("strap address not used");
    a_reg_source: assert property (lw0 && local_req.wdata[0] |=> own_bus_target_address == $past(local_req.wdata[7:1]))
        else $error("register address not used");
    a_apd_local: assert property (lw1 && !local_req.wdata[0] |=> analog_power_down == $past(local_req.wdata[5]))
        else $error("power down bit not applied");
    a_apd_remote: assert property (rw1 && !remote_req.wdata[0] |=> $stable(analog_power_down))
        else $error("remote write changed power down");
    a_logic_pulse: assert property (lw1 && local_req.wdata[1] && !local_req.wdata[0] |=> logic_reset_pulse [*4] ##1 !logic_reset_pulse)
        else $error("logic reset pulse wrong");
    a_full_pulse: assert property (lw1 && local_req.wdata[0] |=> full_reset_pulse [*4] ##1 !full_reset_pulse)
        else $error("full reset pulse wrong");
    a_full_clears_apd: assert property ($rose(full_reset_pulse) |=> !analog_power_down)
        else $error("full reset kept power down");
    a_clk_link_a: assert property (link_a |-> clk_sel == DSRCR_CLK_RECOVERED)
        else $error("link_a clock select wrong");
    a_clk_unlocked: assert property (lw2 ##1 !link_a |-> clk_sel == ($past(local_req.wdata[5]) ? DSRCR_CLK_OSC : DSRCR_CLK_OFF))
        else $error("unlocked clock select wrong");
endmodule : dsrcr_regs_asserts
bind dsrcr_regs dsrcr_regs_asserts u_chk (.clk, .rstn, .local_req, .remote_req, .address_strap_input, .link_a,
    .own_bus_target_address, .analog_power_down, .logic_reset_pulse, .full_reset_pulse, .clk_sel);
